// ---- core/cis_host.sv ----
// cis_host: processor and reader end; issues column words, makes the shift
// clocks and column sync, gathers serial bits, polls the encoder.
// assumes data_ready_i/encoder_word_i come from outside and the word holds while ready.
`timescale 1ns/1ps
`default_nettype none

module cis_host
    import cis_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // link toward the channel
    cis_link_if.host         link,
    // column images in
    input  wire logic [31:0] col_data_i,
    input  wire logic        col_valid_i,
    output logic             col_ready_o,
    // character encoder
    input  wire logic        data_ready_i,
    input  wire logic [15:0] encoder_word_i,
    output logic [15:0]      code_o,
    output logic             code_valid_o,
    output logic             code_err_o,
    // reader load register view
    output logic [31:0]      load_col_o,
    output logic             load_col_valid_o
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        cis_hp_state_t state;
        logic [15:0]   word_hold;
        logic [15:0]   out_word;
        logic          out_req;
        logic          rr_s1;
        logic          rr_s2;
        logic          rr_low_seen;
        logic          dr_s1;
        logic          dr_s2;
        logic [15:0]   enc_s1;
        logic [15:0]   enc_s2;
        logic          sd_s1;
        logic          sd_s2;
        logic [3:0]    phase;
        logic [6:0]    shift_idx;
        logic          odd;
        logic          even;
        logic          csync;
        logic [31:0]   load_reg;
        logic [31:0]   load_col;
        logic          load_col_valid;
        logic [15:0]   code;
        logic          code_valid;
        logic          code_err;
    } cis_hp_regs_t;

    cis_hp_regs_t hp_reg;
    cis_hp_regs_t hp_next;

    always_comb begin
        hp_next = hp_reg;
        hp_next.rr_s1 = link.resume_ready;
        hp_next.rr_s2 = hp_reg.rr_s1;
        hp_next.dr_s1 = data_ready_i;
        hp_next.dr_s2 = hp_reg.dr_s1;
        // encoder word crosses with the ready level, same depth so both settle together
        hp_next.enc_s1 = encoder_word_i;
        hp_next.enc_s2 = hp_reg.enc_s1;
        hp_next.sd_s1 = link.serial_data;
        hp_next.sd_s2 = hp_reg.sd_s1;
        hp_next.load_col_valid = 1'b0;
        hp_next.code_valid     = 1'b0;
        hp_next.code_err       = 1'b0;

        // ************************************************************
        // shift clock divider and column sync
        // ************************************************************
        hp_next.phase = hp_reg.phase + 4'h1;
        if (hp_reg.phase == PHASE_LAST) begin
            hp_next.shift_idx = (hp_reg.shift_idx == SHIFT_LAST) ? 7'h00 : hp_reg.shift_idx + 7'h01;
        end
        hp_next.odd   = (hp_next.phase < ODD_END);
        hp_next.even  = (hp_next.phase >= EVEN_START) && (hp_next.phase < EVEN_END);
        hp_next.csync = (hp_next.shift_idx == SHIFT_LAST) && (hp_next.phase >= SYNC_START);

        if (hp_reg.phase == EVEN_START - 4'h1) begin
            hp_next.load_reg = {hp_reg.load_reg[30:0], hp_reg.sd_s2};
        end
        // column complete, row 1 on top
        if ((hp_reg.phase == EVEN_START) && (hp_reg.shift_idx == ROW_LAST)) begin
            hp_next.load_col       = hp_reg.load_reg;
            hp_next.load_col_valid = 1'b1;
        end

        // ************************************************************
        // processor output sequence
        // ************************************************************
        if (!hp_reg.rr_s2) begin
            hp_next.rr_low_seen = 1'b1;
        end
        unique case (hp_reg.state)
            HP_IDLE: begin
                if (col_valid_i) begin
                    hp_next.out_word    = col_data_i[31:16];
                    hp_next.word_hold   = col_data_i[15:0];
                    hp_next.out_req     = ~hp_reg.out_req;
                    hp_next.rr_low_seen = 1'b0;
                    hp_next.state       = HP_WAIT1;
                end
            end
            HP_WAIT1: begin
                if (hp_reg.rr_low_seen && hp_reg.rr_s2) begin
                    hp_next.out_word    = hp_reg.word_hold;
                    hp_next.out_req     = ~hp_reg.out_req;
                    hp_next.rr_low_seen = 1'b0;
                    hp_next.state       = HP_WAIT2;
                end
            end
            HP_WAIT2: begin
                if (hp_reg.rr_low_seen && hp_reg.rr_s2) begin
                    hp_next.state = HP_POLL;
                end
            end
            HP_POLL: begin
                if (hp_reg.dr_s2) begin
                    hp_next.code = hp_reg.enc_s2;
                    hp_next.code_valid = ~hp_reg.enc_s2[ERR_BIT];
                    hp_next.code_err   = hp_reg.enc_s2[ERR_BIT];
                end
                hp_next.state = HP_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            hp_reg           <= '0;
            hp_reg.state     <= HP_IDLE;
            // park one clock before phase 0, shift 0 so the first odd pulse has full width
            hp_reg.phase     <= PHASE_LAST;
            hp_reg.shift_idx <= SHIFT_LAST;
        end else if (ce_i) begin
            hp_reg <= hp_next;
        end
    end

    assign col_ready_o      = (hp_reg.state == HP_IDLE);
    assign link.out_word    = hp_reg.out_word;
    assign link.out_req     = hp_reg.out_req;
    assign link.odd_clk     = hp_reg.odd;
    assign link.even_clk    = hp_reg.even;
    assign link.column_sync = hp_reg.csync;
    assign code_o           = hp_reg.code;
    assign code_valid_o     = hp_reg.code_valid;
    assign code_err_o       = hp_reg.code_err;
    assign load_col_o       = hp_reg.load_col;
    assign load_col_valid_o = hp_reg.load_col_valid;

endmodule : cis_host

`default_nettype wire

// ---- shared/cis_pkg.sv ----
// cis_pkg: constants and types shared by both ends of the column image serial channel.
// assumes both ends run from one 40 MHz reference clock, each in its own module.
package cis_pkg;

    // ************************************************************
    // word and column geometry
    // ************************************************************
    localparam int unsigned WORD_W        = 16;
    localparam int unsigned WORDS_PER_COL = 2;
    localparam int unsigned GRID_ROWS     = 32;
    localparam int unsigned GRID_COLS     = 19;
    localparam int unsigned FILL_CLOCKS   = 50;
    localparam int unsigned COL_CLOCKS    = GRID_ROWS + FILL_CLOCKS;

    // white (blank) level on the serial line; reset value of the line as well
    localparam logic        WHITE_BIT     = 1'b0;
    // error flag position in the encoder data-ready word
    localparam int unsigned ERR_BIT       = 15;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS   = 25;
    localparam int unsigned SHIFT_PERIOD_NS = 400;
    localparam int unsigned SHIFT_DIV       = SHIFT_PERIOD_NS / CLK_PERIOD_NS;
    // phases within one vertical shift clock
    localparam logic [3:0]  ODD_END         = 4'h4;
    localparam logic [3:0]  EVEN_START      = 4'h8;
    localparam logic [3:0]  EVEN_END        = 4'hC;
    localparam logic [3:0]  SYNC_START      = 4'hC;
    localparam logic [3:0]  PHASE_LAST      = 4'(SHIFT_DIV - 1);
    localparam logic [6:0]  SHIFT_LAST      = 7'(COL_CLOCKS - 1);
    localparam logic [6:0]  ROW_LAST        = 7'(GRID_ROWS - 1);
    localparam logic [3:0]  BIT_LAST        = 4'(WORD_W - 1);
    localparam logic [5:0]  FILL_MAX        = 6'(FILL_CLOCKS);

    // channel end state
    typedef enum logic [1:0] {
        CH_WHITE = 2'b00,
        CH_SHIFT = 2'b01
    } cis_ch_state_t;

    // processor end state, gray along idle, word 1, word 2, poll
    typedef enum logic [1:0] {
        HP_IDLE  = 2'b00,
        HP_WAIT1 = 2'b01,
        HP_WAIT2 = 2'b11,
        HP_POLL  = 2'b10
    } cis_hp_state_t;

endpackage : cis_pkg

// ---- shared/cis_link_if.sv ----
// cis_link_if: wires between the channel end and the processor/reader end.
// assumes the bench instances it and hands one modport to each end.
`timescale 1ns/1ps
`default_nettype none

interface cis_link_if;
    logic [15:0] out_word;
    logic        out_req;
    logic        resume_ready;
    logic        column_sync;
    logic        odd_clk;
    logic        even_clk;
    logic        serial_data;

    modport chan (
        input  out_word,
        input  out_req,
        input  column_sync,
        input  odd_clk,
        input  even_clk,
        output resume_ready,
        output serial_data
    );

    modport host (
        output out_word,
        output out_req,
        output column_sync,
        output odd_clk,
        output even_clk,
        input  resume_ready,
        input  serial_data
    );
endinterface : cis_link_if

`default_nettype wire

// ---- core/cis_channel.sv ----
// cis_channel: special output channel, turns 16-bit words into serial column data.
// assumes the link pins come from another clock domain and are synchronised here;
// out_word is stable whenever out_req has toggled.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - output instruction moves one word to shift register
// - processor stalls until resume_ready returns
// - after load, await column_sync, shift on odd
// - reader shifts serial bits upward on even
// - after sixteen bits, assert resume_ready
// - second word loaded, shifted without new sync
// - after second word, resume_ready then white
// - white fill covers remaining fifty shift clocks
// - exactly two words per column sync period
// - processor polls data-ready between column outputs
// - error bit set means no code translation
// - column order, row1 col1 first, last row32 col19
module cis_channel
    import cis_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // link toward processor and reader
    cis_link_if.chan         link,
    // status
    input  wire logic        underrun_clr_i,
    output logic             busy_o,
    output logic             fill_active_o,
    output logic             fill_done_o,
    output logic             underrun_o,
    output logic [15:0]      column_count_o
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic          req_s1;
        logic          req_s2;
        logic          req_prev;
        logic          cs_s1;
        logic          cs_s2;
        logic          cs_prev;
        logic          odd_s1;
        logic          odd_s2;
        logic          odd_prev;
        cis_ch_state_t state;
        logic [15:0]   x_reg;
        logic          have_word;
        logic [3:0]    bit_cnt;
        logic          word_idx;
        logic          rr;
        logic          sdata;
        logic [5:0]    fill_cnt;
        logic          underrun;
        logic [15:0]   col_cnt;
    } cis_ch_regs_t;

    cis_ch_regs_t ch_reg;
    cis_ch_regs_t ch_next;

    logic req_ev;
    logic cs_rise;
    logic odd_rise;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        ch_next = ch_reg;

        // two flip-flops on out_req, column_sync and odd_clk, third stage for edges
        ch_next.req_s1   = link.out_req;
        ch_next.req_s2   = ch_reg.req_s1;
        ch_next.req_prev = ch_reg.req_s2;
        ch_next.cs_s1    = link.column_sync;
        ch_next.cs_s2    = ch_reg.cs_s1;
        ch_next.cs_prev  = ch_reg.cs_s2;
        ch_next.odd_s1   = link.odd_clk;
        ch_next.odd_s2   = ch_reg.odd_s1;
        ch_next.odd_prev = ch_reg.odd_s2;

        req_ev   = ch_reg.req_s2 ^ ch_reg.req_prev;
        cs_rise  = ch_reg.cs_s2 & ~ch_reg.cs_prev;
        odd_rise = ch_reg.odd_s2 & ~ch_reg.odd_prev;

        // clear first so that a fresh underrun in the same cycle wins
        if (underrun_clr_i) begin
            ch_next.underrun = 1'b0;
        end

        unique case (ch_reg.state)
            CH_WHITE: begin
                if (odd_rise) begin
                    ch_next.sdata = WHITE_BIT;
                    if (ch_reg.fill_cnt < FILL_MAX) begin
                        ch_next.fill_cnt = ch_reg.fill_cnt + 6'h01;
                    end
                end
                if (cs_rise && (ch_reg.have_word || req_ev)) begin
                    ch_next.state    = CH_SHIFT;
                    ch_next.word_idx = 1'b0;
                    ch_next.col_cnt  = ch_reg.col_cnt + 16'h0001;
                end
            end
            CH_SHIFT: begin
                if (odd_rise) begin
                    if (ch_reg.have_word) begin
                        ch_next.sdata   = ch_reg.x_reg[BIT_LAST];
                        ch_next.x_reg   = {ch_reg.x_reg[14:0], WHITE_BIT};
                        ch_next.bit_cnt = ch_reg.bit_cnt + 4'h1;
                        if (ch_reg.bit_cnt == BIT_LAST) begin
                            ch_next.have_word = 1'b0;
                            ch_next.rr        = 1'b1;
                            if (ch_reg.word_idx) begin
                                ch_next.state    = CH_WHITE;
                                ch_next.fill_cnt = 6'h00;
                            end else begin
                                ch_next.word_idx = 1'b1;
                            end
                        end
                    end else begin
                        // late word: keep the line white rather than resend stale bits
                        ch_next.sdata    = WHITE_BIT;
                        ch_next.underrun = 1'b1;
                    end
                end
            end
        endcase

        if (req_ev) begin
            ch_next.x_reg     = link.out_word;
            ch_next.have_word = 1'b1;
            ch_next.bit_cnt   = 4'h0;
            ch_next.rr        = 1'b0;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ch_reg       <= '0;
            ch_reg.state <= CH_WHITE;
            ch_reg.sdata <= WHITE_BIT;
        end else if (ce_i) begin
            ch_reg <= ch_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign link.resume_ready = ch_reg.rr;
    assign link.serial_data  = ch_reg.sdata;
    assign busy_o            = (ch_reg.state == CH_SHIFT);
    assign fill_active_o     = (ch_reg.state == CH_WHITE) && (ch_reg.fill_cnt < FILL_MAX);
    assign fill_done_o       = (ch_reg.fill_cnt == FILL_MAX);
    assign underrun_o        = ch_reg.underrun;
    assign column_count_o    = ch_reg.col_cnt;

endmodule : cis_channel

`default_nettype wire

// ---- sim/cis_chk.sv ----
// cis_chk: assertions on the link between the channel end and the host end.
// assumes one 40 MHz clock; link signals come straight from the interface.
`timescale 1ns/1ps
`default_nettype none

module cis_chk
    import cis_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // link
    input wire logic out_req,
    input wire logic resume_ready,
    input wire logic column_sync,
    input wire logic odd_clk,
    input wire logic even_clk,
    input wire logic serial_data
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // ********************
    // edge ages and counts
    // ********************
    // ages give slack of a few cycles for the synchroniser depth
    logic [3:0] odd_age, req_age;
    logic [6:0] odd_cnt;
    logic [1:0] rr_cnt, req_cnt;
    logic       odd_q, req_q, sync_q, rr_q, seen_sync;
    logic       odd_up, sync_up;
    assign odd_up  = odd_clk && !odd_q;
    assign sync_up = column_sync && !sync_q;

    always_ff @(posedge ref_clk_i) begin
        odd_q  <= odd_clk;
        req_q  <= out_req;
        sync_q <= column_sync;
        rr_q   <= resume_ready;
        if (!rst_n_i) begin
            odd_age   <= 4'hF;
            req_age   <= 4'hF;
            odd_cnt   <= 7'h00;
            rr_cnt    <= 2'h0;
            req_cnt   <= 2'h0;
            seen_sync <= 1'b0;
        end else begin
            odd_age   <= odd_up ? 4'h1 : odd_age + 4'(odd_age != 4'hF);
            req_age   <= (out_req != req_q) ? 4'h1 : req_age + 4'(req_age != 4'hF);
            odd_cnt   <= sync_up ? 7'h00 : odd_cnt + 7'(odd_up);
            rr_cnt    <= sync_up ? 2'h0 : rr_cnt + 2'(resume_ready && !rr_q && rr_cnt != 2'h3);
            req_cnt   <= sync_up ? 2'h0 : req_cnt + 2'(out_req != req_q && req_cnt != 2'h3);
            seen_sync <= seen_sync || sync_up;
        end
    end

    // ********************
    // assertions
    // ********************
    sequence s_odd_pulse;
        odd_clk [*4] ##1 !odd_clk;
    endsequence
    sequence s_even_pulse;
        $rose(even_clk) ##4 $fell(even_clk);
    endsequence
    sequence s_white_run;
        !serial_data [*8];
    endsequence

    wait_sync_a: assert property (!seen_sync |-> !serial_data && !resume_ready)
        else $error("link active before first column sync");
    bit_edge_a: assert property ($changed(serial_data) |-> odd_age inside {[4'h2:4'h6]})
        else $error("serial bit changed away from an odd clock");
    rr_rise_a: assert property ($rose(resume_ready) |-> odd_age inside {[4'h2:4'h6]})
        else $error("resume ready rose away from an odd clock");
    rr_hold_a: assert property ($fell(resume_ready) |-> req_age inside {[4'h2:4'h6]})
        else $error("resume ready fell without a new word");
    req_clear_a: assert property ($changed(out_req) |-> ##[2:6] !resume_ready)
        else $error("new word not taken");
    fill_white_a: assert property ($rose(resume_ready) && rr_cnt == 2'h1 |-> ##20 s_white_run)
        else $error("no white after second word");
    fill_len_a: assert property ($rose(column_sync) |-> odd_cnt == 7'(COL_CLOCKS))
        else $error("column period shift count wrong");
    pair_cnt_a: assert property ($rose(column_sync) |-> req_cnt <= 2'h2)
        else $error("more than two words in a column");
    odd_shape_a: assert property ($rose(odd_clk) |-> s_odd_pulse ##12 $rose(odd_clk))
        else $error("odd clock shape wrong");
    even_phase_a: assert property ($rose(odd_clk) |-> ##8 s_even_pulse)
        else $error("even clock phase wrong");
    sync_row_a: assert property ($rose(column_sync) |-> column_sync [*4] ##1 $rose(odd_clk))
        else $error("row one odd clock not after sync");
endmodule : cis_chk

`default_nettype wire

// ---- sim/column_image_serial_channel_tb_top.sv ----
// column_image_serial_channel_tb_top: channel and host ends joined by the link.
// assumes the host end makes shift clocks and sync; ce held high throughout.
`timescale 1ns/1ps
`default_nettype none

module column_image_serial_channel_tb_top;
    logic        ref_clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [31:0] col_data_i = 32'h0000_0000;
    logic        col_valid_i = 1'b0;
    logic        data_ready_i = 1'b0;
    logic [15:0] encoder_word_i = 16'h0000;
    logic        fill_active_o, fill_done_o, underrun_o, busy_o;
    logic [15:0] column_count_o, code_o;
    logic        col_ready_o, code_valid_o, code_err_o, load_col_valid_o;
    logic [31:0] load_col_o;
    logic        got_v = 1'b0;
    logic        got_e = 1'b0;
    logic [15:0] ncol = 16'h0000;
    int          err_count = 0;
    int          n_checks = 0;
    int          cycles = 0;

    cis_link_if lnk ();
    cis_channel i_cis_channel (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .link(lnk),
        .underrun_clr_i(1'b0), .busy_o(busy_o), .fill_active_o(fill_active_o), .fill_done_o(fill_done_o),
        .underrun_o(underrun_o), .column_count_o(column_count_o));
    cis_host i_cis_host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .link(lnk),
        .col_data_i(col_data_i), .col_valid_i(col_valid_i), .col_ready_o(col_ready_o),
        .data_ready_i(data_ready_i), .encoder_word_i(encoder_word_i), .code_o(code_o),
        .code_valid_o(code_valid_o), .code_err_o(code_err_o), .load_col_o(load_col_o),
        .load_col_valid_o(load_col_valid_o));
    cis_chk i_cis_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .out_req(lnk.out_req),
        .resume_ready(lnk.resume_ready), .column_sync(lnk.column_sync), .odd_clk(lnk.odd_clk),
        .even_clk(lnk.even_clk), .serial_data(lnk.serial_data));

    always #12.5 ref_clk_i = ~ref_clk_i;

    // about 6500 cycles expected; pulses are latched so no negedge sample misses them
    always @(posedge ref_clk_i) begin
        cycles++;
        got_v <= got_v | (code_valid_o === 1'b1);
        got_e <= got_e | (code_err_o === 1'b1);
        if (cycles == 20000) begin
            err_count++;
            $display("ERROR t=%0t run timed out", $time);
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    task automatic chk(input bit ok, input string msg);
        n_checks++;
        if (!ok) begin
            err_count++;
            $display("ERROR t=%0t %s", $time, msg);
        end
    endtask : chk

    task automatic wait_hi(ref logic s, input int lim);
        int n;
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk(s === 1'b1, "wait ran out");
    endtask : wait_hi

    // one column in, reader image compared; code pulses latched meanwhile
    task automatic xfer(input logic [31:0] d, input logic dr, input logic [15:0] enc);
        int n;
        @(negedge ref_clk_i);
        got_v = 1'b0;
        got_e = 1'b0;
        col_data_i = d;
        col_valid_i = 1'b1;
        data_ready_i = dr;
        encoder_word_i = enc;
        wait_hi(col_ready_o, 3000);
        @(negedge ref_clk_i);
        col_valid_i = 1'b0;
        ncol = ncol + 16'h0001;
        // the reader view pulses every column period; wait for this column's sync first
        n = 0;
        while (column_count_o !== ncol && n < 3000) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk(column_count_o === ncol && busy_o === 1'b1, "column not started");
        wait_hi(load_col_valid_o, 3000);
        chk(load_col_o === d, "column image wrong");
        chk(column_count_o === ncol, "column count wrong");
        repeat (100) @(negedge ref_clk_i);
        data_ready_i = 1'b0;
    endtask : xfer

    task automatic t_reset();
        repeat (10) @(negedge ref_clk_i);
        chk(lnk.serial_data === 1'b0 && lnk.resume_ready === 1'b0, "reset link");
        chk(column_count_o === 16'h0000 && col_ready_o === 1'b1, "reset state");
        rst_n_i = 1'b1;
    endtask : t_reset

    task automatic t_plain();
        xfer(32'h8000_0001, 1'b0, 16'h0000);
        chk(got_v === 1'b0 && got_e === 1'b0, "code without data ready");
    endtask : t_plain

    task automatic t_code();
        xfer(32'hC3A5_5A3C, 1'b1, 16'h0123);
        chk(got_v === 1'b1 && got_e === 1'b0 && code_o === 16'h0123, "code lost");
    endtask : t_code

    task automatic t_err();
        xfer(32'h7FFF_FFFE, 1'b1, 16'h8042);
        chk(got_e === 1'b1 && got_v === 1'b0, "error code translated");
    endtask : t_err

    task automatic t_fill();
        xfer(32'hFFFF_FFFF, 1'b0, 16'h0000);
        chk(fill_active_o === 1'b1 && fill_done_o === 1'b0, "fill state");
        wait_hi(fill_done_o, 1200);
        chk(underrun_o === 1'b0, "underrun with timely words");
    endtask : t_fill

    initial begin
        t_reset();
        t_plain();
        t_code();
        t_err();
        t_fill();
        conclude();
    end
endmodule : column_image_serial_channel_tb_top

`default_nettype wire
